// [pwf_pkg.sv]
/*
  Shared constants, register map and carrier types of the four-generator PWM block.
  Assumes a 32-bit APB slave port with an 8-bit byte address.
*/
package pwf_pkg;
  localparam int NGEN        = 4;
  localparam int NOUT        = 8;
  localparam int NFLT        = 4;
  localparam int NEV         = 6;
  localparam int CW          = 16;
  localparam int AW          = 8;
  localparam int DW          = 32;
  localparam int IEW         = 14;
  localparam int TRIG_LSB    = 8;
  localparam int GEN_SEL_BIT = 7;
  localparam int GIDX_LSB    = 5;
  localparam int GIDX_W      = 2;
  localparam int GOFF_W      = 5;
  localparam int FSRC_W      = NGEN * NFLT;
  localparam int MOD_FLT_LSB = NGEN;

  typedef logic [DW-1:0] pwf_word_t;
  typedef logic [AW-1:0] pwf_addr_t;

  // Module-level registers.
  localparam pwf_addr_t OFF_SYNC    = 8'h00;
  localparam pwf_addr_t OFF_INTEN   = 8'h04;
  localparam pwf_addr_t OFF_RIS     = 8'h08;
  localparam pwf_addr_t OFF_MIS     = 8'h0C;
  localparam pwf_addr_t OFF_SQUELCH = 8'h10;
  localparam pwf_addr_t OFF_LEVEL   = 8'h14;
  localparam pwf_addr_t OFF_INVERT  = 8'h18;
  localparam pwf_addr_t OFF_EXTF    = 8'h1C;
  localparam pwf_addr_t OFF_FSRC    = 8'h20;
  localparam pwf_addr_t GEN0_BASE   = 8'h80;

  // Generator registers, offsets inside each 32-byte generator window.
  localparam logic [GOFF_W-1:0] GOFF_PERIOD = 5'h00;
  localparam logic [GOFF_W-1:0] GOFF_CMPA   = 5'h04;
  localparam logic [GOFF_W-1:0] GOFF_CMPB   = 5'h08;
  localparam logic [GOFF_W-1:0] GOFF_INTEN  = 5'h0C;
  localparam logic [GOFF_W-1:0] GOFF_RIS    = 5'h10;
  localparam logic [GOFF_W-1:0] GOFF_MIS    = 5'h14;

  localparam logic [CW-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CW-1:0] CNT_ONE  = 16'h0001;

  // Event bit positions, shared by status, interrupt and trigger masks.
  localparam int EV_ZERO = 0;
  localparam int EV_LOAD = 1;
  localparam int EV_AU   = 2;
  localparam int EV_AD   = 3;
  localparam int EV_BU   = 4;
  localparam int EV_BD   = 5;

  typedef enum logic [1:0] {PWF_UP = 2'b01, PWF_DOWN = 2'b10} pwf_dir_t;

  typedef struct packed {
    logic          period;
    logic          cmpa;
    logic          cmpb;
    logic          inten;
    logic          clr;
    logic          upd;
    logic [CW-1:0] data;
  } pwf_gwr_t;

  typedef struct packed {
    logic [CW-1:0]  period;
    logic [CW-1:0]  cmpa;
    logic [CW-1:0]  cmpb;
    logic [CW-1:0]  act_period;
    logic [IEW-1:0] inten;
    logic [NEV-1:0] ris;
    logic           upd;
    logic           irq;
    logic           trig;
    logic           zero;
    logic           pwm_a;
    logic           pwm_b;
  } pwf_gst_t;
endpackage

// [pwf_sync.sv]
/*
  Two-flop synchroniser for a group of level inputs.
  Assumes the inputs are asynchronous levels that stay long enough to be seen.
*/
`timescale 1ns/1ps
module pwf_sync #(
  parameter int W = 4
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output wire logic [W-1:0] q
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;

  // The first stage feeds only the second stage, to contain metastability.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= '0;
      s2_ff <= '0;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
    end
  end

  assign q = s2_ff;
endmodule // pwf_sync

// [pwf_gen.sv]
/*
  One PWM generator: up/down counter, buffered period and compares, event status and masks.
  Assumes register writes arrive as one-cycle strobes in the carrier struct.
*/
`timescale 1ns/1ps
module pwf_gen (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire pwf_pkg::pwf_gwr_t wr,
  output wire pwf_pkg::pwf_gst_t st
);
  logic [pwf_pkg::CW-1:0]  period_ff, act_period_ff, cmpa_ff, act_cmpa_ff;
  logic [pwf_pkg::CW-1:0]  cmpb_ff, act_cmpb_ff, cnt_ff, nxt_cnt;
  logic [pwf_pkg::IEW-1:0] inten_ff;
  logic [pwf_pkg::NEV-1:0] ris_ff, ev;
  logic                    trig_ff, upd_ff;
  pwf_pkg::pwf_dir_t       dir_ff, nxt_dir;

  // Zero and update; the new half period is used from the zero on, so intervals stay whole.
  wire going_up = (dir_ff == pwf_pkg::PWF_UP);
  wire at_zero  = going_up && (cnt_ff == pwf_pkg::CNT_ZERO);
  wire apply    = at_zero && upd_ff;
  wire [pwf_pkg::CW-1:0] half = apply ? (period_ff >> 1) : (act_period_ff >> 1);
  wire [pwf_pkg::NEV-1:0] clr_mask = wr.clr ? wr.data[pwf_pkg::NEV-1:0] : '0;

  // Counter events; each is a one-cycle pulse while the half period is nonzero.
  assign ev[pwf_pkg::EV_ZERO] = at_zero;
  assign ev[pwf_pkg::EV_LOAD] = going_up && (cnt_ff == half) && (half != pwf_pkg::CNT_ZERO);
  assign ev[pwf_pkg::EV_AU]   = going_up && (cnt_ff == act_cmpa_ff);
  assign ev[pwf_pkg::EV_AD]   = !going_up && (cnt_ff == act_cmpa_ff);
  assign ev[pwf_pkg::EV_BU]   = going_up && (cnt_ff == act_cmpb_ff);
  assign ev[pwf_pkg::EV_BD]   = !going_up && (cnt_ff == act_cmpb_ff);

  // Up to half, back down to zero: zero pulses are 2*half ticks apart.
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_dir = dir_ff;
    case (dir_ff)
      pwf_pkg::PWF_UP: begin
        if (half == pwf_pkg::CNT_ZERO) begin
          nxt_cnt = pwf_pkg::CNT_ZERO;
        end else if (cnt_ff >= half) begin
          nxt_cnt = cnt_ff - pwf_pkg::CNT_ONE;
          nxt_dir = (cnt_ff <= pwf_pkg::CNT_ONE) ? pwf_pkg::PWF_UP : pwf_pkg::PWF_DOWN;
        end else begin
          nxt_cnt = cnt_ff + pwf_pkg::CNT_ONE;
        end
      end
      pwf_pkg::PWF_DOWN: begin
        if (cnt_ff <= pwf_pkg::CNT_ONE) begin
          nxt_cnt = pwf_pkg::CNT_ZERO;
          nxt_dir = pwf_pkg::PWF_UP;
        end else begin
          nxt_cnt = cnt_ff - pwf_pkg::CNT_ONE;
        end
      end
      default: begin
        nxt_cnt = pwf_pkg::CNT_ZERO;
        nxt_dir = pwf_pkg::PWF_UP;
      end
    endcase
  end

  // Programmed values; a later write simply replaces the pending one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_ff <= pwf_pkg::CNT_ZERO;
      cmpa_ff   <= pwf_pkg::CNT_ZERO;
      cmpb_ff   <= pwf_pkg::CNT_ZERO;
      inten_ff  <= '0;
    end else begin
      if (wr.period) period_ff <= wr.data;
      if (wr.cmpa) cmpa_ff <= wr.data;
      if (wr.cmpb) cmpb_ff <= wr.data;
      if (wr.inten) inten_ff <= wr.data[pwf_pkg::IEW-1:0];
    end
  end

  // Active values change only at a zero with an update pending; a new request wins over the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_period_ff <= pwf_pkg::CNT_ZERO;
      act_cmpa_ff   <= pwf_pkg::CNT_ZERO;
      act_cmpb_ff   <= pwf_pkg::CNT_ZERO;
      upd_ff        <= 1'b0;
    end else begin
      upd_ff <= wr.upd | (upd_ff & ~apply);
      if (apply) begin
        act_period_ff <= period_ff;
        act_cmpa_ff   <= cmpa_ff;
        act_cmpb_ff   <= cmpb_ff;
      end
    end
  end

  // Status sets on the event whatever the masks; an event beats a same-cycle clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff  <= pwf_pkg::CNT_ZERO;
      dir_ff  <= pwf_pkg::PWF_UP;
      ris_ff  <= '0;
      trig_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      dir_ff  <= nxt_dir;
      ris_ff  <= ev | (ris_ff & ~clr_mask);
      trig_ff <= |(ev & inten_ff[pwf_pkg::TRIG_LSB +: pwf_pkg::NEV]);
    end
  end

  // Status bundle; compare outputs are high while the counter is below the compare.
  assign st.period     = period_ff;
  assign st.cmpa       = cmpa_ff;
  assign st.cmpb       = cmpb_ff;
  assign st.act_period = act_period_ff;
  assign st.inten      = inten_ff;
  assign st.ris        = ris_ff;
  assign st.upd        = upd_ff;
  assign st.irq        = |(ris_ff & inten_ff[pwf_pkg::NEV-1:0]);
  assign st.trig       = trig_ff;
  assign st.zero       = at_zero;
  assign st.pwm_a      = (cnt_ff < act_cmpa_ff);
  assign st.pwm_b      = (cnt_ff < act_cmpb_ff);
endmodule // pwf_gen

// [pwf_pwm.sv]
/*
  Top of the PWM block: APB registers, four generators, fault handling and output polarity.
  Assumes an APB master on pclk and asynchronous fault levels, active high after sensing.
*/
// What this block does
// - Each generator masks its interrupt and trigger sources with an enable mask.
// - Twelve sources: interrupt and trigger for zero, load, A up/down, B up/down.
// - Period, rounded down to an even value, is the tick count between successive zero pulses.
// - Programmed period is kept apart from the active one and read back.
// - A new period write replaces any pending one.
// - Module interrupt mask has one bit per generator and per fault input.
// - Module status has one bit per generator and per fault input.
// - Raw and masked module status are both readable.
// - A squelched output is forced to a fixed level while its fault lasts.
// - Unsquelched outputs keep their normal waveform during faults.
// - With extended handling, a level bit picks high or low drive.
// - Without level setting or extended handling, squelched outputs go low.
// - The level bit does nothing for unsquelched outputs.
// - An invert bit per output makes it active low.
// - Pending updates take effect at the next zero after a sync request.
// - Event and fault status bits clear on writing one; zero leaves them.
// - Generator fault is the OR of selected inputs, input zero by default.
`timescale 1ns/1ps
module pwf_pwm (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [pwf_pkg::AW-1:0]      paddr,
  input  wire logic [pwf_pkg::DW-1:0]      pwdata,
  output wire logic [pwf_pkg::DW-1:0]      prdata,
  output wire logic                        pready,
  output wire logic                        pslverr,
  input  wire logic [pwf_pkg::NFLT-1:0]    fault_in,
  output wire logic [pwf_pkg::NOUT-1:0]    pwm_out,
  output wire logic [pwf_pkg::NGEN-1:0]    gen_trig,
  output wire logic                        irq
);
  logic [pwf_pkg::DW-1:0]     prdata_ff;
  logic                       pready_ff, pslverr_ff, irq_ff;
  logic [pwf_pkg::NOUT-1:0]   mod_inten_ff, squelch_ff, level_ff, invert_ff, pwm_out_ff;
  logic [pwf_pkg::NFLT-1:0]   flt_ris_ff;
  logic [pwf_pkg::NGEN-1:0]   extf_ff;
  logic [pwf_pkg::FSRC_W-1:0] fsrc_ff;
  wire  [pwf_pkg::NFLT-1:0]   fs;
  wire  [pwf_pkg::NGEN-1:0]   gfault, g_irq;
  pwf_pkg::pwf_gst_t          st [pwf_pkg::NGEN];
  pwf_pkg::pwf_gwr_t          gwr [pwf_pkg::NGEN];

  // Fault inputs come from pins and are synchronised before use.
  pwf_sync #(.W(pwf_pkg::NFLT)) u_fsync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (fault_in),
    .q       (fs)
  );

  // APB decode; the answer is ready in the first access cycle.
  wire setup  = psel && !penable;
  wire acc    = psel && penable && pready_ff;
  wire wr_acc = acc && pwrite;
  wire is_gen = paddr[pwf_pkg::GEN_SEL_BIT];
  wire [pwf_pkg::GIDX_W-1:0] gidx = paddr[pwf_pkg::GIDX_LSB +: pwf_pkg::GIDX_W];
  wire [pwf_pkg::GOFF_W-1:0] goff = paddr[pwf_pkg::GOFF_W-1:0];
  wire mw = wr_acc && !is_gen;

  // Module-level selects.
  wire h_sync = !is_gen && (paddr == pwf_pkg::OFF_SYNC);
  wire h_ien  = !is_gen && (paddr == pwf_pkg::OFF_INTEN);
  wire h_ris  = !is_gen && (paddr == pwf_pkg::OFF_RIS);
  wire h_mis  = !is_gen && (paddr == pwf_pkg::OFF_MIS);
  wire h_sq   = !is_gen && (paddr == pwf_pkg::OFF_SQUELCH);
  wire h_lvl  = !is_gen && (paddr == pwf_pkg::OFF_LEVEL);
  wire h_inv  = !is_gen && (paddr == pwf_pkg::OFF_INVERT);
  wire h_extf = !is_gen && (paddr == pwf_pkg::OFF_EXTF);
  wire h_fsrc = !is_gen && (paddr == pwf_pkg::OFF_FSRC);

  // Generator-window selects.
  wire hg_per = is_gen && (goff == pwf_pkg::GOFF_PERIOD);
  wire hg_ca  = is_gen && (goff == pwf_pkg::GOFF_CMPA);
  wire hg_cb  = is_gen && (goff == pwf_pkg::GOFF_CMPB);
  wire hg_ien = is_gen && (goff == pwf_pkg::GOFF_INTEN);
  wire hg_ris = is_gen && (goff == pwf_pkg::GOFF_RIS);
  wire hg_mis = is_gen && (goff == pwf_pkg::GOFF_MIS);
  wire hit = h_sync | h_ien | h_ris | h_mis | h_sq | h_lvl | h_inv | h_extf | h_fsrc
           | hg_per | hg_ca | hg_cb | hg_ien | hg_ris | hg_mis;

  // Module status: generator interrupts low, sticky fault bits high.
  wire [pwf_pkg::NOUT-1:0] mod_raw = {flt_ris_ff, g_irq};
  wire [pwf_pkg::NOUT-1:0] mod_mis = mod_raw & mod_inten_ff;
  wire [pwf_pkg::NGEN-1:0] upd_pend;
  wire [pwf_pkg::NFLT-1:0] flt_clr = (mw && h_ris) ? pwdata[pwf_pkg::MOD_FLT_LSB +: pwf_pkg::NFLT]
                                                   : '0;

  // Read mux for the selected generator.
  pwf_pkg::pwf_gst_t gs;
  assign gs = st[gidx];
  wire [pwf_pkg::DW-1:0] gen_rd =
      hg_per ? pwf_pkg::pwf_word_t'(gs.period) :
      hg_ca  ? pwf_pkg::pwf_word_t'(gs.cmpa) :
      hg_cb  ? pwf_pkg::pwf_word_t'(gs.cmpb) :
      hg_ien ? pwf_pkg::pwf_word_t'(gs.inten) :
      hg_ris ? pwf_pkg::pwf_word_t'(gs.ris) :
      hg_mis ? pwf_pkg::pwf_word_t'(gs.ris & gs.inten[pwf_pkg::NEV-1:0]) : '0;

  // Read mux for module registers; unused bits read as zero.
  wire [pwf_pkg::DW-1:0] mod_rd =
      h_sync ? pwf_pkg::pwf_word_t'(upd_pend) :
      h_ien  ? pwf_pkg::pwf_word_t'(mod_inten_ff) :
      h_ris  ? pwf_pkg::pwf_word_t'(mod_raw) :
      h_mis  ? pwf_pkg::pwf_word_t'(mod_mis) :
      h_sq   ? pwf_pkg::pwf_word_t'(squelch_ff) :
      h_lvl  ? pwf_pkg::pwf_word_t'(level_ff) :
      h_inv  ? pwf_pkg::pwf_word_t'(invert_ff) :
      h_extf ? pwf_pkg::pwf_word_t'(extf_ff) :
      h_fsrc ? pwf_pkg::pwf_word_t'(fsrc_ff) : '0;

  // Read data and error are captured in the setup cycle, held through access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= '0;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= setup;
      if (setup) begin
        prdata_ff  <= (is_gen ? gen_rd : mod_rd);
        pslverr_ff <= !hit;
      end
    end
  end

  // Module control registers; writes to unmapped addresses change nothing.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_inten_ff <= '0;
      squelch_ff   <= '0;
      level_ff     <= '0;
      invert_ff    <= '0;
      extf_ff      <= '0;
      fsrc_ff      <= '0;
    end else if (mw) begin
      if (h_ien) mod_inten_ff <= pwdata[pwf_pkg::NOUT-1:0];
      if (h_sq) squelch_ff <= pwdata[pwf_pkg::NOUT-1:0];
      if (h_lvl) level_ff <= pwdata[pwf_pkg::NOUT-1:0];
      if (h_inv) invert_ff <= pwdata[pwf_pkg::NOUT-1:0];
      if (h_extf) extf_ff <= pwdata[pwf_pkg::NGEN-1:0];
      if (h_fsrc) fsrc_ff <= pwdata[pwf_pkg::FSRC_W-1:0];
    end
  end

  // Fault status is sticky; a fault still present beats the write-one clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_ris_ff <= '0;
      irq_ff     <= 1'b0;
    end else begin
      flt_ris_ff <= fs | (flt_ris_ff & ~flt_clr);
      irq_ff     <= |mod_mis;
    end
  end

  // Generators, their write strobes and their fault selection.
  genvar g;
  generate
    for (g = 0; g < pwf_pkg::NGEN; g++) begin : g_gen
      wire sel = wr_acc && is_gen && (gidx == pwf_pkg::GIDX_W'(g));
      assign gwr[g].period = sel && hg_per;
      assign gwr[g].cmpa   = sel && hg_ca;
      assign gwr[g].cmpb   = sel && hg_cb;
      assign gwr[g].inten  = sel && hg_ien;
      assign gwr[g].clr    = sel && hg_ris;
      assign gwr[g].upd    = mw && h_sync && pwdata[g];
      assign gwr[g].data   = pwdata[pwf_pkg::CW-1:0];
      assign g_irq[g]      = st[g].irq;
      assign upd_pend[g]   = st[g].upd;
      assign gen_trig[g]   = st[g].trig;
      // Default mode uses input zero only; extended mode ORs the selected inputs.
      assign gfault[g] = extf_ff[g] ? |(fs & fsrc_ff[g*pwf_pkg::NFLT +: pwf_pkg::NFLT])
                                    : fs[0];
      pwf_gen u_gen (
        .pclk    (pclk),
        .presetn (presetn),
        .wr      (gwr[g]),
        .st      (st[g])
      );
    end
  endgenerate

  // Output stage; polarity first, then a squelch overrides with a fixed level.
  genvar k;
  generate
    for (k = 0; k < pwf_pkg::NOUT; k++) begin : g_out
      wire gf   = gfault[k/2];
      wire raw  = (k % 2 == 0) ? st[k/2].pwm_a : st[k/2].pwm_b;
      wire lvl  = extf_ff[k/2] && level_ff[k];
      wire norm = raw ^ invert_ff[k];
      wire nxt_pwm = (gf && squelch_ff[k]) ? lvl : norm;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pwm_out_ff[k] <= 1'b0;
        end else begin
          pwm_out_ff[k] <= nxt_pwm;
        end
      end
    end
  endgenerate

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign pwm_out = pwm_out_ff;
  assign irq     = irq_ff;

  // Helper for period checks: ticks since the last zero of generator 0.
  logic [pwf_pkg::CW-1:0] since_ff;
  logic                   seen_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_ff <= pwf_pkg::CNT_ONE;
      seen_ff  <= 1'b0;
    end else begin
      since_ff <= st[0].zero ? pwf_pkg::CNT_ONE : since_ff + pwf_pkg::CNT_ONE;
      seen_ff  <= seen_ff | st[0].zero;
    end
  end
  wire [pwf_pkg::CW-1:0] exp_per = {st[0].act_period[pwf_pkg::CW-1:1], 1'b0};
  wire [pwf_pkg::AW-1:0] a_g0_ris = pwf_pkg::GEN0_BASE | pwf_pkg::pwf_addr_t'(pwf_pkg::GOFF_RIS);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_trig_mask;
    (st[0].inten[pwf_pkg::TRIG_LSB +: pwf_pkg::NEV] == '0) |=> !st[0].trig;
  endproperty
  a_trig_mask: assert property (p_trig_mask) else $error("masked trigger fired");
  property p_raw_set;
    st[0].zero |=> st[0].ris[pwf_pkg::EV_ZERO];
  endproperty
  a_raw_set: assert property (p_raw_set) else $error("zero event not latched");
  property p_period;
    st[0].zero && seen_ff && (exp_per != pwf_pkg::CNT_ZERO) |-> since_ff == exp_per;
  endproperty
  a_period: assert property (p_period) else $error("zero spacing wrong");
  property p_read_prog;
    acc && !pwrite && (paddr == pwf_pkg::GEN0_BASE) |-> prdata[pwf_pkg::CW-1:0] == st[0].period;
  endproperty
  a_read_prog: assert property (p_read_prog) else $error("period readback wrong");
  property p_overwrite;
    wr_acc && (paddr == pwf_pkg::GEN0_BASE) |=> st[0].period == $past(pwdata[pwf_pkg::CW-1:0]);
  endproperty
  a_overwrite: assert property (p_overwrite) else $error("pending period not replaced");
  property p_apply;
    st[0].zero && st[0].upd && !gwr[0].upd |=> (st[0].act_period == $past(st[0].period))
                                               && !st[0].upd;
  endproperty
  a_apply: assert property (p_apply) else $error("update not applied at zero");
  property p_mod_mask;
    (mod_inten_ff == '0) |=> !irq;
  endproperty
  a_mod_mask: assert property (p_mod_mask) else $error("masked module irq");
  property p_flt_status;
    fs[0] |=> flt_ris_ff[0] ##1 mod_raw[pwf_pkg::MOD_FLT_LSB];
  endproperty
  a_flt_status: assert property (p_flt_status) else $error("fault status lost");
  property p_squelch;
    gfault[0] && squelch_ff[0] |=> pwm_out[0] == $past(extf_ff[0] && level_ff[0]);
  endproperty
  a_squelch: assert property (p_squelch) else $error("squelch level wrong");
  property p_default_low;
    !extf_ff[0] && fs[0] && squelch_ff[0] |=> !pwm_out[0];
  endproperty
  a_default_low: assert property (p_default_low) else $error("default drive not low");
  property p_pass;
    !squelch_ff[0] |=> pwm_out[0] == $past(st[0].pwm_a ^ invert_ff[0]);
  endproperty
  a_pass: assert property (p_pass) else $error("waveform not passed");
  property p_w1c;
    wr_acc && (paddr == a_g0_ris) && pwdata[pwf_pkg::EV_ZERO] && !st[0].zero
      |=> !st[0].ris[pwf_pkg::EV_ZERO];
  endproperty
  a_w1c: assert property (p_w1c) else $error("status not cleared");
  property p_reset_zero;
    $rose(presetn) |-> (squelch_ff == '0) && (level_ff == '0) && (invert_ff == '0);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("config not zero at reset");

  c_apply: cover property (st[0].zero && st[0].upd);
  c_high: cover property (gfault[1] && squelch_ff[2] && extf_ff[1] && level_ff[2]);
  c_irq: cover property ($rose(irq));
  c_err: cover property (acc && pslverr);
endmodule // pwf_pwm

// [tb.sv]
/* Self-checking bench of the four-generator PWM block: registers, periods, masks, faults.
   Assumes the package and design files are compiled first; the bench drives every port. */
`timescale 1ns/1ps
module tb;
  logic        pclk = 0;
  logic        presetn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [3:0]  fault_in = '0;
  logic [7:0]  pwm_out;
  logic [3:0]  gen_trig;
  logic [31:0] r;
  logic        e;
  int          g;
  int          bad_count = 0;
  int          cmp_count = 0;

  pwf_pwm i_pwf_pwm (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fault_in(fault_in), .pwm_out(pwm_out), .gen_trig(gen_trig), .irq(irq));

  // Free-running 50 MHz clock.
  always #10 pclk = ~pclk;

  // Single exit point, so a hang and a normal end report the same way.
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", s, exp, got);
    end
  endtask

  // One APB transfer; an idle edge follows so the next setup never lands in this time step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      print_verdict();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, string s);
    apb(1'h0, a, 32'h0);
    chk(s, x, r & m);
  endtask

  // Cycles between two trigger pulses of generator 0, bounded so a dead counter cannot hang.
  task automatic gap();
    int n;
    n = 0;
    while (gen_trig[0] !== 1'h1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    g = 0;
    do begin
      @(posedge pclk);
      g++;
    end while (gen_trig[0] !== 1'h1 && g < 50);
    if (g >= 50) begin
      bad_count++;
      print_verdict();
    end
  endtask

  task automatic t_reset();
    rd(8'h04, '1, 32'h0, "inten");
    rd(8'h10, '1, 32'h0, "squelch");
    rd(8'h14, '1, 32'h0, "level");
    rd(8'h18, '1, 32'h0, "invert");
    rd(8'h8C, '1, 32'h0, "gen_inten");
    rd(8'h40, '1, 32'h0, "unmapped");
    chk("pslverr", 32'h1, {31'h0, e});
  endtask

  // Masked triggers stay quiet; pending periods only act after a sync request.
  task automatic t_period();
    g = 0;
    repeat (10) begin
      @(posedge pclk);
      g += int'(gen_trig[0] === 1'h1);
    end
    chk("trig_masked", 32'h0, g);
    apb(1'h1, 8'h8C, 32'h100);
    apb(1'h1, 8'h80, 32'h8);
    apb(1'h1, 8'h80, 32'hA);
    rd(8'h80, '1, 32'hA, "period_rd");
    gap();
    chk("gap_nosync", 32'h1, g);
    apb(1'h1, 8'h00, 32'h1);
    gap();
    gap();
    chk("gap_sync", 32'hA, g);
  endtask

  task automatic t_irq();
    rd(8'h90, 32'h1, 32'h1, "gen_ris");
    rd(8'h94, '1, 32'h0, "gen_mis");
    rd(8'h08, 32'hF, 32'h0, "ris_off");
    apb(1'h1, 8'h8C, 32'h101);
    rd(8'h08, 32'hF, 32'h1, "ris_gen");
    rd(8'h0C, '1, 32'h0, "mis_off");
    chk("irq_off", 32'h0, {31'h0, irq});
    apb(1'h1, 8'h04, 32'h1);
    rd(8'h0C, '1, 32'h1, "mis_on");
    chk("irq_on", 32'h1, {31'h0, irq});
  endtask

  // Inverted idle outputs make a forced low level visible on the pins.
  task automatic t_fault();
    apb(1'h1, 8'h18, 32'h3);
    apb(1'h1, 8'h10, 32'h1);
    chk("out_inv", 32'h3, {24'h0, pwm_out});
    fault_in <= 4'h1;
    repeat (6) @(posedge pclk);
    chk("out_sq_lo", 32'h2, {24'h0, pwm_out});
    apb(1'h1, 8'h1C, 32'h1);
    apb(1'h1, 8'h20, 32'h1);
    // Output 1 keeps level low, so a leak of the level into an unsquelched pin shows.
    apb(1'h1, 8'h14, 32'h1);
    repeat (6) @(posedge pclk);
    chk("out_sq_hi", 32'h3, {24'h0, pwm_out});
    rd(8'h08, 32'h10, 32'h10, "ris_flt");
    fault_in <= 4'h0;
    repeat (6) @(posedge pclk);
    apb(1'h1, 8'h08, 32'h0);
    rd(8'h08, 32'h10, 32'h10, "ris_keep");
    apb(1'h1, 8'h08, 32'h10);
    rd(8'h08, 32'h10, 32'h0, "ris_clr");
  endtask

  // Reset for four cycles, then the scenarios in order.
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_reset();
    t_period();
    t_irq();
    t_fault();
    print_verdict();
  end
endmodule // tb
